/* File: rtl/tpw_pkg.sv */
// Purpose: Constants for the pulse-width capture timer block
// Assumes: Avalon-MM slave with 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses
package tpw_pkg;
  localparam logic [7:0]  OFS_COUNT   = 8'h00;
  localparam logic [7:0]  OFS_CAP_A   = 8'h04;
  localparam logic [7:0]  OFS_CAP_B   = 8'h08;
  localparam logic [7:0]  OFS_MODE    = 8'h0c;
  localparam logic [7:0]  OFS_OUTCTL  = 8'h10;
  localparam logic [7:0]  OFS_CAPCTL  = 8'h14;
  localparam logic [7:0]  OFS_IRQ     = 8'h18;
  // Mode register fields
  localparam int          MODE_LO_BIT = 0;
  localparam int          MODE_HI_BIT = 1;
  localparam int          OVF_BIT     = 2;
  localparam logic [1:0]  MODE_STOP   = 2'h0;
  localparam logic [1:0]  MODE_FREE   = 2'h1;
  localparam logic [1:0]  MODE_CLRST  = 2'h2;
  // Output control fields
  localparam int          LVR_BIT     = 0;
  localparam int          LVS_BIT     = 1;
  localparam int          TGLB_BIT    = 2;
  // Capture control fields
  localparam int          SELA_B_BIT  = 0;
  localparam int          REVA_BIT    = 1;
  localparam int          EDGA_LO     = 2;
  localparam int          EDGB_LO     = 4;
  // Edge select codes
  localparam logic [1:0]  EDGE_FALL   = 2'h0;
  localparam logic [1:0]  EDGE_RISE   = 2'h1;
  localparam logic [1:0]  EDGE_BOTH   = 2'h3;
  // Irq register fields
  localparam int          IRQA_BIT    = 0;
  localparam int          IRQB_BIT    = 1;
  localparam int          MSKA_BIT    = 2;
  localparam int          MSKB_BIT    = 3;
  // Reset values and counter maximum
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [15:0] CAP_RST     = 16'h0000;
  localparam logic [3:0]  CAPCTL_RST  = 4'h0;
  localparam logic [1:0]  IRQMSK_RST  = 2'h3;
endpackage : tpw_pkg

/* File: rtl/tpw_timer_capture.sv */
// Purpose: 16-bit timer with two capture/compare registers for pulse width
// Assumes: core_clk is the count clock; trigger pins are asynchronous
// Notes:   Interval, pulse generator and one-shot modes are not built
//
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps

// Overview of operation
// RULE1: Mode 01 counts freely, never cleared
// RULE2: Trigger A valid edge captures into B
// RULE3: Trigger B edge captures into A
// RULE4: Edge detectors allow both edges valid
// RULE5: Reverse phase: A captures opposite edge (code: with the both-edge setting A captures nothing)
// RULE6: Mode 10 is clear-and-start on A
// RULE7: Clear-and-start edge stores B, clears counter
// RULE8: Overflow flag sticky until software clears
// RULE9: Software adds 10000H for overflowed period
// RULE10: Software ignores borrow across wraps
// RULE11: Count read never disturbs counting
// RULE12: A trigger selectable; B always from A
// RULE13: Capture raises interrupt; software reads register
// RULE14: No compare rewrite while running
// RULE15: Duty rewrite only right after match
// RULE16: Software follows masked rewrite sequence
// RULE17: Toggle enable low blocks match-B inversion
// RULE18: Level bits set output while stopped
// RULE19: Level pair: keep, low, high, prohibited
// RULE20: Software keeps level bits zero normally
// RULE21: Overflow sets flag, wraps, keeps counting
// RULE22: Interrupt pulse one clock after capture
// RULE23: Edge needs two equal samples
// RULE24: Reverse capture silent; B edge interrupts
// RULE25: New capture overwrites older value
module tpw_timer_capture
  import tpw_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Board pins
  input  wire logic        trigger_input_a,
  input  wire logic        trigger_input_b,
  output logic             timer_output_pin,
  // Interrupt requests
  output logic             match_a_irq,
  output logic             match_b_irq
);

  // Edge decode shared by both trigger inputs
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (sel)
      EDGE_FALL: edge_hit = fall;
      EDGE_RISE: edge_hit = rise;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  logic [15:0] timer_count_r;
  logic [15:0] capture_compare_a_r;
  logic [15:0] capture_compare_b_r;
  logic [1:0]  mode_r;
  logic        overflow_flag_r;
  logic        match_b_toggle_enable_r;
  logic [1:0]  level_r;
  logic [5:0]  capctl_r;
  logic [1:0]  irq_mask_r;
  logic [1:0]  irq_flag_r;
  logic [1:0]  sync_a_r;
  logic [1:0]  sync_b_r;
  logic [1:0]  smp_a_r;
  logic [1:0]  smp_b_r;
  logic        lvl_a_r;
  logic        lvl_b_r;
  logic        cap_a_ev_r;
  logic        cap_b_ev_r;
  logic        ack_r;
  logic        running;
  logic        edge_a;
  logic        edge_a_rev;
  logic        edge_b;
  logic        do_cap_a;
  logic        irq_a_ev;
  logic        wr_cycle;
  logic        rd_cycle;
  logic [31:0] rd_nxt;

  assign running  = mode_r != MODE_STOP;
  // Writes land on the edge where waitrequest is seen low, not before
  assign wr_cycle = avs_write & ack_r & clk_en;
  assign rd_cycle = avs_read & ~ack_r & clk_en;

  // Two-stage synchronisers on the pins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a_r <= 2'h0;
      sync_b_r <= 2'h0;
    end else if (clk_en) begin
      sync_a_r <= {sync_a_r[0], trigger_input_a};
      sync_b_r <= {sync_b_r[0], trigger_input_b};
    end
  end

  // Filter: level accepted after two equal samples
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      smp_a_r <= 2'h0;
      smp_b_r <= 2'h0;
      lvl_a_r <= 1'b0;
      lvl_b_r <= 1'b0;
    end else if (clk_en) begin
      smp_a_r <= {smp_a_r[0], sync_a_r[1]};
      smp_b_r <= {smp_b_r[0], sync_b_r[1]};
      if (smp_a_r[1] == smp_a_r[0]) lvl_a_r <= smp_a_r[0]; // RULE23
      if (smp_b_r[1] == smp_b_r[0]) lvl_b_r <= smp_b_r[0]; // RULE23
    end
  end

  // Both-edge setting supported on edge_a and edge_b; edge_a_rev turns code 11 into 10, which never hits
  assign edge_a     = running & edge_hit(capctl_r[EDGA_LO +: 2], lvl_a_r,
                      (smp_a_r[1] == smp_a_r[0]) ? smp_a_r[0] : lvl_a_r); // RULE4
  assign edge_a_rev = running & edge_hit(~capctl_r[EDGA_LO +: 2] & 2'h1 |
                      (capctl_r[EDGA_LO +: 2] & 2'h2), lvl_a_r,
                      (smp_a_r[1] == smp_a_r[0]) ? smp_a_r[0] : lvl_a_r); // RULE5
  assign edge_b     = running & edge_hit(capctl_r[EDGB_LO +: 2], lvl_b_r,
                      (smp_b_r[1] == smp_b_r[0]) ? smp_b_r[0] : lvl_b_r); // RULE4

  // Source for register A: pin B, or pin A in normal or reverse phase
  always_comb begin
    if (capctl_r[SELA_B_BIT]) begin
      do_cap_a = edge_b; // RULE3 RULE12
      irq_a_ev = edge_b;
    end else if (capctl_r[REVA_BIT]) begin
      do_cap_a = edge_a_rev; // RULE5
      irq_a_ev = edge_b;     // RULE24
    end else begin
      do_cap_a = edge_a; // RULE12
      irq_a_ev = edge_a;
    end
  end

  // Counter; mode 10 clears on a pin A edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_count_r <= CNT_RST;
    end else if (clk_en) begin
      if (!running) timer_count_r <= CNT_RST;
      else if (mode_r == MODE_CLRST && edge_a) timer_count_r <= CNT_RST; // RULE6 RULE7
      else timer_count_r <= timer_count_r + 16'h0001; // RULE1 RULE21
    end
  end

  // Overflow flag: hardware set wins over software clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (running && timer_count_r == CNT_MAX) overflow_flag_r <= 1'b1; // RULE8 RULE21
      else if (wr_cycle && avs_address == OFS_MODE && !avs_writedata[OVF_BIT])
        overflow_flag_r <= 1'b0; // RULE8
    end
  end

  // Captures overwrite older values and win over software writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_compare_a_r <= CAP_RST;
      capture_compare_b_r <= CAP_RST;
    end else if (clk_en) begin
      if (do_cap_a) capture_compare_a_r <= timer_count_r; // RULE3 RULE12 RULE25
      else if (wr_cycle && avs_address == OFS_CAP_A)
        capture_compare_a_r <= avs_writedata[15:0];
      if (edge_a) capture_compare_b_r <= timer_count_r; // RULE2 RULE7 RULE25
      else if (wr_cycle && avs_address == OFS_CAP_B)
        capture_compare_b_r <= avs_writedata[15:0];
    end
  end

  // Capture events delayed one clock to the interrupt
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_a_ev_r  <= 1'b0;
      cap_b_ev_r  <= 1'b0;
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
    end else if (clk_en) begin
      cap_a_ev_r  <= irq_a_ev;
      cap_b_ev_r  <= edge_a;
      match_a_irq <= cap_a_ev_r & ~irq_mask_r[0]; // RULE13 RULE22
      match_b_irq <= cap_b_ev_r & ~irq_mask_r[1]; // RULE13 RULE22
    end
  end

  // Pending flags: set wins over clear-by-zero write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag_r <= 2'h0;
      irq_mask_r <= IRQMSK_RST;
    end else if (clk_en) begin
      if (wr_cycle && avs_address == OFS_IRQ) begin
        irq_mask_r <= avs_writedata[MSKB_BIT:MSKA_BIT];
        irq_flag_r <= irq_flag_r & avs_writedata[IRQB_BIT:IRQA_BIT]
                      | {cap_b_ev_r, cap_a_ev_r};
      end else begin
        irq_flag_r <= irq_flag_r | {cap_b_ev_r, cap_a_ev_r};
      end
    end
  end

  // Control registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r                  <= MODE_STOP;
      match_b_toggle_enable_r <= 1'b0;
      level_r                 <= 2'h0;
      capctl_r                <= {2'h0, CAPCTL_RST};
    end else if (wr_cycle) begin
      if (avs_address == OFS_MODE)
        mode_r <= avs_writedata[MODE_HI_BIT:MODE_LO_BIT];
      if (avs_address == OFS_OUTCTL) begin
        match_b_toggle_enable_r <= avs_writedata[TGLB_BIT];
        level_r                 <= avs_writedata[LVS_BIT:LVR_BIT];
      end
      if (avs_address == OFS_CAPCTL) capctl_r <= avs_writedata[5:0];
    end
  end

  // Output pin: level bits act while stopped; 11 is ignored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_output_pin <= 1'b0;
    end else if (clk_en) begin
      if (!running) begin
        case (level_r)
          2'h1:    timer_output_pin <= 1'b0; // RULE18 RULE19
          2'h2:    timer_output_pin <= 1'b1; // RULE18 RULE19
          default: timer_output_pin <= timer_output_pin; // RULE19
        endcase
      end else if (match_b_toggle_enable_r && timer_count_r == capture_compare_b_r) begin
        timer_output_pin <= ~timer_output_pin; // RULE17
      end
    end
  end

  // Read mux; count read has no side effect
  always_comb begin
    rd_nxt = 32'h0;
    case (avs_address)
      OFS_COUNT:  rd_nxt = {16'h0, timer_count_r}; // RULE11
      OFS_CAP_A:  rd_nxt = {16'h0, capture_compare_a_r};
      OFS_CAP_B:  rd_nxt = {16'h0, capture_compare_b_r};
      OFS_MODE:   rd_nxt = {29'h0, overflow_flag_r, mode_r};
      OFS_OUTCTL: rd_nxt = {29'h0, match_b_toggle_enable_r, level_r};
      OFS_CAPCTL: rd_nxt = {26'h0, capctl_r};
      OFS_IRQ:    rd_nxt = {28'h0, irq_mask_r, irq_flag_r};
      default:    rd_nxt = 32'h0;
    endcase
  end

  // Bus answer one clock after the request; unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h0;
    end else if (clk_en) begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (rd_cycle) avs_readdata <= rd_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) avs_waitrequest <= 1'b1;
    else if (clk_en) avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
  end

  // Checks
  sequence s_wrap;
    running && timer_count_r == CNT_MAX && mode_r == MODE_FREE && clk_en;
  endsequence

  chk_free_wrap: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE21
    s_wrap ##1 clk_en |-> timer_count_r == CNT_RST && overflow_flag_r)
    else $error("counter wrap or overflow flag wrong");

  chk_free_count: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
    mode_r == MODE_FREE && $past(mode_r) == MODE_FREE && $past(clk_en) && clk_en
    |-> timer_count_r == $past(timer_count_r) + 16'h0001)
    else $error("free-running counter did not advance");

  chk_capture_b: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
    edge_a && clk_en |=> capture_compare_b_r == $past(timer_count_r))
    else $error("register B missed capture");

  chk_clear_start: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
    mode_r == MODE_CLRST && edge_a && clk_en |=> timer_count_r == CNT_RST)
    else $error("clear-and-start did not clear");

  chk_ovf_sticky: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8
    overflow_flag_r && !(avs_write && avs_address == OFS_MODE) |=> overflow_flag_r)
    else $error("overflow flag dropped");

  chk_irq_delay: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE22
    edge_a && clk_en && !irq_mask_r[1] && mode_r == $past(mode_r) ##1 clk_en
    |=> match_b_irq)
    else $error("capture interrupt not one clock later");

  chk_toggle_off: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE17
    running && !match_b_toggle_enable_r |=> timer_output_pin == $past(timer_output_pin))
    else $error("output toggled while disabled");

  chk_level_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE19
    !running && level_r == 2'h2 && clk_en |=> timer_output_pin)
    else $error("level set did not drive high");

  chk_capture_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
    capctl_r[SELA_B_BIT] && edge_b && clk_en |=> capture_compare_a_r == $past(timer_count_r))
    else $error("register A missed pin B capture");

endmodule : tpw_timer_capture

/* File: verif/tpw_pulse_src.sv */
// Purpose: Pulse source on the two trigger pins
// Assumes: Pin changes land just after a rising edge of core_clk
// Notes:   Glitch task exists only for the noise-filter scenario
`timescale 1ns/1ps
module tpw_pulse_src (
  // Clock
  input  wire logic core_clk,
  // Trigger pins
  output logic      trigger_input_a,
  output logic      trigger_input_b
);
  initial begin
    trigger_input_a = 1'b0;
    trigger_input_b = 1'b0;
  end
  // High for len cycles, then low for len cycles; len well above 2
  task automatic pulse(input logic onb, input int len);
    @(posedge core_clk);
    if (onb) trigger_input_b <= 1'b1; else trigger_input_a <= 1'b1;
    repeat (len) @(posedge core_clk);
    if (onb) trigger_input_b <= 1'b0; else trigger_input_a <= 1'b0;
    repeat (len) @(posedge core_clk);
  endtask : pulse
  // One-cycle spike, too short to count as an edge
  task automatic glitch_a;
    @(posedge core_clk);
    trigger_input_a <= 1'b1;
    @(posedge core_clk);
    trigger_input_a <= 1'b0;
  endtask : glitch_a
endmodule : tpw_pulse_src

/* File: verif/timer_pulse_width_capture_bench.sv */
// Purpose: Self-checking bench for the pulse-width capture timer
// Assumes: Trigger pins come from the pulse source model
// Notes:   Expectations use edge spacing, so capture latency may vary
`timescale 1ns/1ps
module timer_pulse_width_capture_bench;
  import tpw_pkg::*;
  typedef struct {logic [7:0] adr; logic [31:0] exp;} tpw_row_t;
  logic              core_clk, rst_b, clk_en, avs_read, avs_write;
  logic [7:0]        avs_address;
  logic [31:0]       avs_writedata, q, v, vs;
  wire logic [31:0]  avs_readdata;
  wire logic         avs_waitrequest, trigger_input_a, trigger_input_b;
  wire logic         timer_output_pin, match_a_irq, match_b_irq;
  int                n_fail, samples_checked, cyc, t_rd, na, nb, ta, tb, t0, ts;
  logic [31:0]       vv [3];
  tpw_row_t          rows [8] = '{'{OFS_COUNT, 32'h0}, '{OFS_CAP_A, 32'h0},
    '{OFS_CAP_B, 32'h0}, '{OFS_MODE, 32'h0}, '{OFS_OUTCTL, 32'h0},
    '{OFS_CAPCTL, 32'h0}, '{OFS_IRQ, 32'hc}, '{8'h1c, 32'h0}};
  // Level pair in [2:1], expected pin in [0]
  logic [2:0]        lv [7] = '{3'h5, 3'h1, 3'h2, 3'h6, 3'h5, 3'h7, 3'h2};

  tpw_timer_capture DUT (.core_clk, .rst_b, .clk_en, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .trigger_input_a,
    .trigger_input_b, .timer_output_pin, .match_a_irq, .match_b_irq);
  tpw_pulse_src src (.core_clk, .trigger_input_a, .trigger_input_b);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (match_a_irq === 1'b1) begin na <= na + 1; ta <= cyc; end
    if (match_b_irq === 1'b1) begin nb <= nb + 1; tb <= cyc; end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a; avs_write <= wr; avs_read <= ~wr; avs_writedata <= d;
    do begin @(posedge core_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
    check(32'(k < 50), 32'h1);
    q = avs_readdata;
    t_rd = cyc;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task wait_ev(input logic isb, input int c0);
    int k;
    k = 0;
    while ((isb ? nb : na) == c0 && k < 100) begin @(posedge core_clk); k++; end
    check(32'(k < 100), 32'h1);
  endtask : wait_ev

  // Two edges len apart must give captures and interrupts len apart
  task meas(input logic onb, input int len);
    int c0;
    c0 = onb ? na : nb;
    fork
      src.pulse(onb, len);
      begin
        wait_ev(~onb, c0);
        bus(1'b0, onb ? OFS_CAP_A : OFS_CAP_B, 32'h0);
        v = q;
        t0 = onb ? ta : tb;
      end
    join
    wait_ev(~onb, c0 + 1);
    bus(1'b0, onb ? OFS_CAP_A : OFS_CAP_B, 32'h0);
    check({16'h0, q[15:0] - v[15:0]}, 32'(len));
    check(32'((onb ? ta : tb) - t0), 32'(len));
  endtask : meas

  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (80000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    int k;
    rst_b = 1'b0; clk_en = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 8'h0; avs_writedata = 32'h0;
    cyc = 0; na = 0; nb = 0; ta = 0; tb = 0; n_fail = 0; samples_checked = 0;
    repeat (12) @(posedge core_clk);
    check({31'h0, avs_waitrequest}, 32'h1);
    rst_b <= 1'b1;
    bus(1'b1, OFS_COUNT, 32'h1234);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].adr, 32'h0);
      check(q, rows[i].exp);
    end
    foreach (lv[i]) begin
      bus(1'b1, OFS_OUTCTL, 32'(lv[i][2:1]));
      repeat (2) @(posedge core_clk);
      check({31'h0, timer_output_pin}, {31'h0, lv[i][0]});
    end
    check({31'h0, timer_output_pin}, 32'h0);
    bus(1'b1, OFS_OUTCTL, 32'h0);
    // Free run, both edges on both pins, A sourced from pin B
    bus(1'b1, OFS_MODE, 32'(MODE_FREE));
    bus(1'b1, OFS_IRQ, 32'h0);
    bus(1'b1, OFS_CAPCTL, 32'h3d);
    bus(1'b0, OFS_COUNT, 32'h0);
    vs = q;
    ts = t_rd;
    meas(1'b0, 30);
    meas(1'b1, 24);
    bus(1'b0, OFS_COUNT, 32'h0);
    check(q - vs, 32'(t_rd - ts));
    k = nb;
    src.glitch_a();
    repeat (20) @(posedge core_clk);
    check(32'(nb), 32'(k));
    // Reverse phase on pin A, rising valid edge on both pins
    bus(1'b1, OFS_CAPCTL, 32'h16);
    k = na;
    t0 = nb;
    fork
      src.pulse(1'b0, 30);
      begin
        wait_ev(1'b1, t0);
        bus(1'b0, OFS_CAP_B, 32'h0);
        v = q;
      end
    join
    check(32'(nb - t0), 32'h1);
    bus(1'b0, OFS_CAP_A, 32'h0);
    check({16'h0, q[15:0] - v[15:0]}, 32'd30);
    check(32'(na), 32'(k));
    vs = q;
    src.pulse(1'b1, 10);
    wait_ev(1'b0, k);
    bus(1'b0, OFS_CAP_A, 32'h0);
    check(q, vs);
    // Clear and start on rising edges of pin A, period 51
    bus(1'b1, OFS_CAPCTL, 32'h04);
    bus(1'b1, OFS_MODE, 32'(MODE_CLRST));
    for (int i = 0; i < 3; i++) begin
      k = nb;
      fork
        src.pulse(1'b0, 25);
        begin
          wait_ev(1'b1, k);
          bus(1'b0, OFS_CAP_B, 32'h0);
          vv[i] = q;
          bus(1'b0, OFS_COUNT, 32'h0);
          check(32'(q < 16), 32'h1);
        end
      join
    end
    check(vv[2], vv[1]);
    check(vv[2], 32'd50);
    // Overflow sets a sticky flag and the count wraps
    bus(1'b1, OFS_MODE, 32'(MODE_FREE));
    bus(1'b0, OFS_COUNT, 32'h0);
    vs = q;
    ts = t_rd;
    k = 0;
    do begin bus(1'b0, OFS_MODE, 32'h0); k++; end while (q[OVF_BIT] !== 1'b1 && k < 25000);
    check(32'(k < 25000), 32'h1);
    bus(1'b0, OFS_COUNT, 32'h0);
    check(32'(q < 16), 32'h1);
    check(32'h10000 + q - vs, 32'(t_rd - ts));
    repeat (20) @(posedge core_clk);
    bus(1'b0, OFS_MODE, 32'h0);
    check(q, 32'h5);
    bus(1'b1, OFS_MODE, 32'(MODE_FREE));
    bus(1'b0, OFS_MODE, 32'h0);
    check(q, 32'h1);
    // Duty rewrite while running, in the masked update order
    check({31'h0, timer_output_pin}, 32'h0);
    bus(1'b1, OFS_IRQ, 32'h8);
    bus(1'b1, OFS_OUTCTL, 32'h0);
    bus(1'b1, OFS_CAP_B, 32'h200);
    @(posedge core_clk);
    bus(1'b1, OFS_OUTCTL, 32'h4);
    bus(1'b1, OFS_IRQ, 32'h8);
    bus(1'b1, OFS_IRQ, 32'h0);
    bus(1'b0, OFS_CAP_B, 32'h0);
    check(q, 32'h200);
    k = 0;
    while (timer_output_pin !== 1'b1 && k < 1000) begin @(posedge core_clk); k++; end
    check(32'(k < 1000), 32'h1);
    bus(1'b0, OFS_COUNT, 32'h0);
    check(q, 32'h203);
    // Enable low freezes the count
    bus(1'b0, OFS_COUNT, 32'h0);
    vs = q;
    clk_en <= 1'b0;
    repeat (10) @(posedge core_clk);
    clk_en <= 1'b1;
    bus(1'b0, OFS_COUNT, 32'h0);
    check(q - vs, 32'h3);
    // Second reset in mid-run
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({31'h0, timer_output_pin}, 32'h0);
    rst_b <= 1'b1;
    bus(1'b0, OFS_MODE, 32'h0);
    check(q, 32'h0);
    bus(1'b0, OFS_COUNT, 32'h0);
    check(q, 32'h0);
    wrap_up();
  end
endmodule : timer_pulse_width_capture_bench
